// File: bench/slave_model.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Memory or peripheral slave on the far side of the bus
// ------------------------------------------------------------
module slave_model (
	input  wire logic                           clk,
	input  wire logic                           srst,
	input  wire multibeat_pkg::bus_ctrl_type    bus_ctrl,
	input  wire logic [multibeat_pkg::DATA_W-1:0] data_out,
	input  var  int                             beats,
	input  var  int                             wt,
	output logic                                transfer_ack_n,
	output logic [multibeat_pkg::DATA_W-1:0]    data_in
);
	import multibeat_pkg::*;

	int                left;
	int                cnt;
	logic [DATA_W-1:0] cur;

	// Lanes carry the word only in an acknowledged read clock, else its inverse
	assign data_in = (!transfer_ack_n && bus_ctrl.read) ? cur : ~cur;

	// Beats left, wait states and the acknowledge
	always @(posedge clk) begin
		if (srst) begin
			left           <= 0;
			cnt            <= 0;
			cur            <= 32'h0;
			transfer_ack_n <= 1'b1;
		end else if (!bus_ctrl.transfer_start_n) begin
			left           <= beats;
			cnt            <= 0;
			transfer_ack_n <= (wt != 0);
		end else if (left != 0) begin
			if (!transfer_ack_n) begin
				// A read draws its next word at the end of this clock; write data is not kept
				if (bus_ctrl.read) begin
					cur <= $urandom;
				end
				left           <= left - 1;
				cnt            <= 0;
				transfer_ack_n <= !(left > 1 && wt == 0);
			end else begin
				cnt            <= cnt + 1;
				transfer_ack_n <= (cnt + 1 < wt);
			end
		end
	end

endmodule : slave_model

`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Bench for the multi-beat bus master
// ------------------------------------------------------------
module tb;
	import multibeat_pkg::*;

	logic          clk, srst, req_valid, req_ready, wr_valid, wr_ready;
	logic          rd_valid, data_oe, transfer_ack_n;
	request_type   req_in, cur;
	logic [31:0]   wr_data, data_out, data_in;
	read_beat_type rd_beat;
	bus_ctrl_type  bus_ctrl;
	int            beats, wt, errors, n_checks, cyc, nb, bpw, pb, beat, starts, code;
	bit            active, after, mode_next;
	logic [31:0]   words[$];
	logic [31:0]   w[4];
	logic [32:0]   rdq[$];

	multibeat_bus_master i_multibeat_bus_master (
		.clk(clk), .srst(srst), .req_in(req_in), .req_valid(req_valid),
		.req_ready(req_ready), .wr_data(wr_data), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .rd_beat(rd_beat), .rd_valid(rd_valid),
		.bus_ctrl(bus_ctrl), .data_out(data_out), .data_oe(data_oe),
		.data_in(data_in), .transfer_ack_n(transfer_ack_n)
	);

	slave_model i_slave_model (
		.clk(clk), .srst(srst), .bus_ctrl(bus_ctrl), .data_out(data_out),
		.beats(beats), .wt(wt), .transfer_ack_n(transfer_ack_n), .data_in(data_in)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		if (errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	// Size code of a byte count
	function automatic int code_of(input int n);
		return (n == 16) ? 3 : (n == 4) ? 0 : n;
	endfunction : code_of

	function automatic request_type rand_req();
		logic [63:0] v;
		request_type r;
		v      = {$urandom, $urandom};
		r      = v[$bits(request_type)-1:0];
		r.port = port_type'($urandom_range(2));
		return r;
	endfunction : rand_req

	// Offer up to n words; stops at the first refusal
	task automatic push_words(input int n, output int got);
		logic [31:0] d;
		got = 0;
		for (int i = 0; i < n; i++) begin
			d = $urandom;
			wr_data  <= d;
			wr_valid <= 1'b1;
			@(posedge clk);
			if (!wr_ready) break;
			words.push_back(d);
			got++;
		end
		wr_valid <= 1'b0;
		@(posedge clk);
	endtask : push_words

	// One request, with the expected beat plan worked out first
	task automatic run_op(input request_type r);
		int ob;
		bit burst;
		cur   = r;
		ob    = (r.op == OP_LINE) ? 16 : (1 << r.op);
		pb    = (r.port == PORT_8) ? 1 : (r.port == PORT_16) ? 2 : 4;
		nb    = (ob > pb) ? ob / pb : 1;
		bpw   = (r.op == OP_LINE) ? nb / 4 : nb;
		burst = r.burst_en || r.dram;
		code  = (!burst && ob > pb) ? code_of(pb) : code_of(ob);
		beats <= burst ? nb : 1;
		for (int i = 0; i < 4; i++) begin
			if (r.write && i < ((r.op == OP_LINE) ? 4 : 1)) w[i] = words.pop_front();
		end
		beat   = 0;
		starts = 0;
		active = 1;
		req_in    <= r;
		req_valid <= 1'b1;
		do @(posedge clk); while (!req_ready);
		req_valid <= 1'b0;
		while (beat < nb) @(posedge clk);
		repeat (2) @(posedge clk);
		check(starts, burst ? 1 : nb);
		check(rdq.size(), 0);
		active = 0;
	endtask : run_op

	// ------------------------------------------------------------
	// Clock, time limit and bus model
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			give_verdict();
		end
	end

	// Expected bus beats, compared at every start and acknowledge
	always @(posedge clk) begin
		if (!srst && active) begin
			if (after) check(data_oe, 1'b0);
			if (mode_next) check(bus_ctrl.access_mode_flag, cur.supervisor);
			after     = 0;
			mode_next = 0;
			if (!bus_ctrl.transfer_start_n) begin
				starts++;
				mode_next = 1;
				check(bus_ctrl.access_mode_flag, cur.is_code);
				check({bus_ctrl.transfer_type, bus_ctrl.read}, {cur.ttype, !cur.write});
			end
			if (!transfer_ack_n && beat < nb) begin
				check(bus_ctrl.addr, {cur.addr[27:4], cur.addr[3:0] + 4'(beat * pb)});
				check(bus_ctrl.xfer_width_code, code);
				if (cur.write) begin
					check({data_oe, data_out},
						{1'b1, w[beat / bpw] << (beat % bpw * 8 * pb)});
				end else begin
					rdq.push_back({data_in, beat == nb - 1});
				end
				beat++;
				after = cur.write && beat == nb;
			end
		end
		if (!srst && rd_valid) check(rd_beat, rdq.pop_front());
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		int          got;
		request_type r;
		srst      = 1'b1;
		req_in    = '0;
		req_valid = 1'b0;
		wr_data   = 32'h0;
		wr_valid  = 1'b0;
		beats     = 1;
		wt        = 0;
		void'($urandom(56725));
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		// Fill the write queue until refused, then drain all but one longword past a slow slave
		wt <= 2;
		push_words(20, got);
		check(got, FIFO_DEPTH);
		for (int k = 0; k < 6; k++) begin
			r       = rand_req();
			r.write = 1'b1;
			r.op    = (k < 3) ? OP_LINE : OP_LONG;
			run_op(r);
		end
		// Random mix of operands, ports, modes and wait states
		for (int k = 0; k < 70; k++) begin
			r = rand_req();
			wt <= $urandom_range(2);
			if (r.write) push_words((r.op == OP_LINE) ? 4 : 1, got);
			run_op(r);
		end
		give_verdict();
	end

endmodule : tb

`default_nettype wire

// File: src/multibeat_bus_master.sv
// Function
// - Write beat clock two: start off, privilege, data
// - Hold write data through wait states
// - Burst line write steps address by the bytes of one beat (port width)
// - Release data bus after fourth longword
// - Burst disabled: split into separate transfers; dram requests still burst
// - Inhibited size code shows port or operand
// - Never line code when burst inhibited
// - DRAM wide operands always burst
// - Inhibited access is one to sixteen transfers
// - First clock: attributes valid, start asserted
// - Mode pin: code/data, then supervisor/user
// - Byte code one, word code two
// - Read captures lanes only on acknowledge
// - Inhibited: step address, keep attributes, restart
// - Release data bus after last inhibited write
// - Burst enabled: one start for whole operand
// - Bursting line uses size code three
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Write data queue
// ----------------------------------------------------------------
module word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic [WIDTH-1:0]           in_data,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	output logic [WIDTH-1:0]                out_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic             push;
	logic             pop;

	// Handshakes on both sides
	assign in_ready  = (level != CW'(DEPTH));
	assign out_valid = (level != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			level <= level + CW'(push) - CW'(pop);
		end
	end
endmodule : word_fifo

// ----------------------------------------------------------------
// Multi-beat external bus master
// ----------------------------------------------------------------
module multibeat_bus_master (
	input  wire logic                          clk,
	input  wire logic                          srst,
	input  wire multibeat_pkg::request_type    req_in,
	input  wire logic                          req_valid,
	output logic                               req_ready,
	input  wire logic [multibeat_pkg::DATA_W-1:0] wr_data,
	input  wire logic                          wr_valid,
	output logic                               wr_ready,
	output multibeat_pkg::read_beat_type       rd_beat,
	output logic                               rd_valid,
	output multibeat_pkg::bus_ctrl_type        bus_ctrl,
	output logic [multibeat_pkg::DATA_W-1:0]   data_out,
	output logic                               data_oe,
	input  wire logic [multibeat_pkg::DATA_W-1:0] data_in,
	input  wire logic                          transfer_ack_n
);
	import multibeat_pkg::*;

	typedef enum {ST_IDLE, ST_WAIT, ST_START, ST_DATA} state_type;

	state_type              state;
	state_type              next_state;
	request_type            req;
	logic                   bursting;
	logic [2:0]             lane_lg;
	logic [4:0]             beats_left;
	logic [2:0]             word_init;
	logic [2:0]             word_left;
	logic                   take;
	logic                   ack;
	logic                   last;
	logic                   data_ok_new;
	logic                   data_ok_held;
	logic                   load_first;
	logic                   load_next;
	logic                   fifo_pop;
	logic                   fifo_valid;
	logic [DATA_W-1:0]      fifo_data;
	logic [LEVEL_W-1:0]     fifo_level;
	logic                   wr_ready_q;

	// ----------------------------------------------------------------
	// Size arithmetic
	// ----------------------------------------------------------------
	function automatic logic [2:0] op_log2(input operand_type op);
		unique case (op)
			OP_BYTE: op_log2 = 3'h0;
			OP_WORD: op_log2 = 3'h1;
			OP_LONG: op_log2 = 3'h2;
			OP_LINE: op_log2 = 3'h4;
		endcase
	endfunction : op_log2

	function automatic logic [2:0] port_log2(input port_type port);
		unique case (port)
			PORT_8:  port_log2 = 3'h0;
			PORT_16: port_log2 = 3'h1;
			default: port_log2 = 3'h2;
		endcase
	endfunction : port_log2

	// Log2 of the bytes moved per beat
	function automatic logic [2:0] lane_log2(input request_type r);
		lane_log2 = (port_log2(r.port) < op_log2(r.op)) ? port_log2(r.port) : op_log2(r.op);
	endfunction : lane_log2

	// Beats for the whole operand, one to sixteen
	function automatic logic [4:0] beat_count(input request_type r);
		beat_count = 5'h01 << (op_log2(r.op) - lane_log2(r));
	endfunction : beat_count

	// Beats drawn from one queued longword, minus one
	function automatic logic [2:0] word_beats(input request_type r);
		logic [2:0] wl;
		wl = (op_log2(r.op) > 3'h2) ? 3'h2 : op_log2(r.op);
		word_beats = 3'((4'h1 << (wl - lane_log2(r))) - 4'h1);
	endfunction : word_beats

	// Operand code when bursting, port code when split
	function automatic logic [1:0] width_code(input request_type r, input logic burst);
		logic [1:0] opc;
		unique case (r.op)
			OP_BYTE: opc = SIZE_BYTE;
			OP_WORD: opc = SIZE_WORD;
			OP_LONG: opc = SIZE_LONG;
			OP_LINE: opc = SIZE_LINE;
		endcase
		width_code = opc;
		if (!burst && op_log2(r.op) > port_log2(r.port)) begin
			unique case (r.port)
				PORT_8:  width_code = SIZE_BYTE;
				PORT_16: width_code = SIZE_WORD;
				default: width_code = SIZE_LONG;
			endcase
		end
	endfunction : width_code

	// ----------------------------------------------------------------
	// Write data queue instance
	// ----------------------------------------------------------------
	word_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) write_queue (
		.clk       (clk),
		.srst      (srst),
		.in_data   (wr_data),
		.in_valid  (wr_valid && wr_ready_q),
		.in_ready  (),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.level     (fifo_level)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	assign take = req_valid && req_ready;
	assign ack  = !transfer_ack_n;
	assign last = (beats_left == 5'h01);

	// Writes wait until every longword of the operand is queued
	assign data_ok_new  = !req_in.write ||
		(fifo_level >= ((req_in.op == OP_LINE) ? LINE_WORDS : SINGLE_WORDS));
	assign data_ok_held = !req.write ||
		(fifo_level >= ((req.op == OP_LINE) ? LINE_WORDS : SINGLE_WORDS));

	// Next state
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (take) begin
					next_state = data_ok_new ? ST_START : ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (data_ok_held) begin
					next_state = ST_START;
				end
			end
			ST_START: begin
				next_state = ST_DATA;
			end
			ST_DATA: begin
				if (ack) begin
					if (last) begin
						next_state = ST_IDLE;
					end else if (bursting) begin
						next_state = ST_DATA;
					end else begin
						next_state = ST_START;
					end
				end
			end
		endcase
	end

	// State and request acceptance
	always_ff @(posedge clk) begin
		if (srst) begin
			state     <= ST_IDLE;
			req_ready <= 1'b0;
		end else begin
			state     <= next_state;
			req_ready <= (next_state == ST_IDLE);
		end
	end

	// Request latch and beat counting
	always_ff @(posedge clk) begin
		if (srst) begin
			req        <= '0;
			bursting   <= 1'b0;
			lane_lg    <= '0;
			beats_left <= '0;
			word_init  <= '0;
		end else if (take) begin
			req        <= req_in;
			bursting   <= req_in.burst_en || req_in.dram;
			lane_lg    <= lane_log2(req_in);
			beats_left <= beat_count(req_in);
			word_init  <= word_beats(req_in);
		end else if (state == ST_DATA && ack) begin
			beats_left <= beats_left - 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// Address and attribute pins
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			bus_ctrl <= '0;
			bus_ctrl.transfer_start_n <= 1'b1;
			bus_ctrl.read <= 1'b1;
		end else begin
			if (take) begin
				bus_ctrl.addr            <= req_in.addr;
				bus_ctrl.transfer_type   <= req_in.ttype;
				bus_ctrl.read            <= !req_in.write;
				bus_ctrl.xfer_width_code <= width_code(req_in, req_in.burst_en || req_in.dram);
			end else if (state == ST_DATA && ack && !last) begin
				// Step within the line; attributes stay put
				bus_ctrl.addr[LINE_LSB-1:0] <= bus_ctrl.addr[LINE_LSB-1:0] +
					4'(4'h1 << lane_lg);
			end
			bus_ctrl.transfer_start_n <= (next_state != ST_START);
			unique case (next_state)
				ST_START: bus_ctrl.access_mode_flag <=
					(state == ST_IDLE) ? req_in.is_code : req.is_code;
				ST_DATA:  bus_ctrl.access_mode_flag <= req.supervisor;
				default:  bus_ctrl.access_mode_flag <= MODE_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Write data path
	// ----------------------------------------------------------------
	assign load_first = (next_state == ST_START) && (state == ST_IDLE || state == ST_WAIT) &&
		((state == ST_IDLE) ? req_in.write : req.write);
	assign load_next  = (state == ST_DATA) && ack && !last && req.write && (word_left == '0);
	assign fifo_pop   = (load_first || load_next) && fifo_valid;

	// Shift register that drives the upper lanes
	always_ff @(posedge clk) begin
		if (srst) begin
			data_out  <= '0;
			word_left <= '0;
		end else if (load_first) begin
			data_out  <= fifo_data;
			word_left <= (state == ST_IDLE) ? word_beats(req_in) : word_init;
		end else if (load_next) begin
			data_out  <= fifo_data;
			word_left <= word_init;
		end else if (state == ST_DATA && ack && !last && req.write) begin
			data_out  <= data_out << (BYTE_BITS << lane_lg);
			word_left <= word_left - 3'h1;
		end
	end

	// Drive only in data clocks, hold through waits
	always_ff @(posedge clk) begin
		if (srst) begin
			data_oe <= 1'b0;
		end else begin
			data_oe <= (next_state == ST_DATA) && req.write;
		end
	end

	// Queue space, registered for the core
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ready_q <= 1'b0;
		end else begin
			wr_ready_q <= (fifo_level < LEVEL_W'(FIFO_DEPTH - 1));
		end
	end
	assign wr_ready = wr_ready_q;

	// ----------------------------------------------------------------
	// Read data path
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_valid <= 1'b0;
			rd_beat  <= '0;
		end else begin
			rd_valid <= (state == ST_DATA) && ack && !req.write;
			if (state == ST_DATA && ack && !req.write) begin
				rd_beat.data <= data_in;
				rd_beat.last <= last;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence start_clock;
		!bus_ctrl.transfer_start_n;
	endsequence

	sequence waiting_beat;
		state == ST_DATA && transfer_ack_n;
	endsequence

	sequence taken_beat;
		state == ST_DATA && !transfer_ack_n;
	endsequence

	start_one_clock_a: assert property (start_clock |=> bus_ctrl.transfer_start_n)
		else $error("start strobe held past one clock");
	mode_code_a: assert property (start_clock |->
		bus_ctrl.access_mode_flag == req.is_code ##1 bus_ctrl.access_mode_flag == req.supervisor)
		else $error("access mode wrong around start");
	write_data_drive_a: assert property (start_clock ##0 !bus_ctrl.read |=> data_oe)
		else $error("write data not driven in second clock");
	wait_data_hold_a: assert property (waiting_beat ##0 data_oe |=> data_oe && $stable(data_out))
		else $error("write data changed during wait state");
	last_release_a: assert property (taken_beat ##0 last |=> !data_oe && state == ST_IDLE)
		else $error("data bus not released after last beat");
	no_line_split_a: assert property (state != ST_IDLE && !bursting |->
		bus_ctrl.xfer_width_code != SIZE_LINE) else $error("line code while split");
	burst_step_a: assert property (taken_beat ##0 !last ##0 bursting |=> bus_ctrl.transfer_start_n
		&& bus_ctrl.addr[LINE_LSB-1:0] == $past(bus_ctrl.addr[LINE_LSB-1:0]) + 4'(4'h1 << lane_lg))
		else $error("burst beat did not step address");
	split_restart_a: assert property (taken_beat ##0 !last ##0 !bursting |=> start_clock ##0
		$stable(bus_ctrl.xfer_width_code) && $stable(bus_ctrl.transfer_type) && $stable(bus_ctrl.read))
		else $error("split transfer did not restart cleanly");
	read_capture_a: assert property (taken_beat ##0 !req.write |=> rd_valid && rd_beat.data ==
		$past(data_in)) else $error("read beat not captured");
	busy_no_accept_a: assert property (state != ST_IDLE |-> !req_ready)
		else $error("request accepted while busy");
	beat_range_a: assert property (state == ST_START |-> beats_left >= 5'h01 && beats_left <= 5'h10)
		else $error("beat count out of range");
	byte_code_a: assert property (start_clock ##0 req.op == OP_BYTE |->
		bus_ctrl.xfer_width_code == SIZE_BYTE) else $error("byte size code wrong");

endmodule : multibeat_bus_master
`default_nettype wire

// File: src/multibeat_pkg.sv
// ----------------------------------------------------------------
// Shared types and constants of the multi-beat bus master
// ----------------------------------------------------------------
package multibeat_pkg;

	localparam int ADDR_W     = 28;
	localparam int DATA_W     = 32;
	localparam int FIFO_DEPTH = 16;
	localparam int LEVEL_W    = 5;

	// Size codes on the width pins
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_LINE = 2'h3;

	// Levels of the access mode pin
	localparam logic MODE_CODE  = 1'b1;
	localparam logic MODE_SUPER = 1'b1;
	localparam logic MODE_IDLE  = 1'b0;

	// Longwords that a write must have queued before it starts
	localparam logic [LEVEL_W-1:0] LINE_WORDS   = 5'h04;
	localparam logic [LEVEL_W-1:0] SINGLE_WORDS = 5'h01;

	// Byte lane width and low address bits that step within a line
	localparam logic [5:0] BYTE_BITS = 6'h08;
	localparam int         LINE_LSB  = 4;

	typedef enum logic [1:0] {OP_BYTE, OP_WORD, OP_LONG, OP_LINE} operand_type;
	typedef enum logic [1:0] {PORT_8, PORT_16, PORT_32} port_type;

	// One request from the core side
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              write;
		logic [1:0]        ttype;
		logic              is_code;
		logic              supervisor;
		operand_type       op;
		port_type          port;
		logic              burst_en;
		logic              dram;
	} request_type;

	// Transfer attributes driven onto the pins
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [1:0]        transfer_type;
		logic              read;
		logic [1:0]        xfer_width_code;
		logic              transfer_start_n;
		logic              access_mode_flag;
	} bus_ctrl_type;

	// One read beat handed back to the core
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic              last;
	} read_beat_type;

endpackage : multibeat_pkg
